// ### adc8_pkg.sv
// Shared constants and types for the 8-bit SAR converter control block
package adc8_pkg;
    // Register addresses on the special function register bus
    localparam logic [7:0] ADDR_PAIR = 8'hBA;
    localparam logic [7:0] ADDR_CHAN = 8'hBB;
    localparam logic [7:0] ADDR_CLKGAIN = 8'hBC;
    localparam logic [7:0] ADDR_RESULT = 8'hBE;
    localparam logic [7:0] ADDR_CTRL = 8'hE8;
    localparam logic [7:0] ADDR_GT = 8'hC4;
    localparam logic [7:0] ADDR_LT = 8'hC5;
    // Reset values
    localparam logic [7:0] RST_PAIR = 8'h00;
    localparam logic [7:0] RST_CHAN = 8'h00;
    localparam logic [7:0] RST_CLKGAIN = 8'hF8;
    localparam logic [7:0] RST_RESULT = 8'h00;
    localparam logic [7:0] RST_CTRL = 8'h00;
    localparam logic [7:0] RST_GT = 8'hFF;
    localparam logic [7:0] RST_LT = 8'h00;
    // Field positions
    localparam int CTRL_ON_BIT = 7;
    localparam int CTRL_TRACK_BIT = 6;
    localparam int CTRL_DONE_BIT = 5;
    localparam int CTRL_BUSY_BIT = 4;
    localparam int CTRL_SRC_LSB = 1;
    localparam int CTRL_WIN_BIT = 0;
    localparam int CLK_DIV_LSB = 3;
    localparam int GAIN_LSB = 0;
    // Start source codes
    localparam logic [2:0] SRC_SOFTWARE = 3'h0;
    localparam logic [2:0] SRC_TIMER3 = 3'h1;
    localparam logic [2:0] SRC_PIN = 3'h2;
    localparam logic [2:0] SRC_TIMER2 = 3'h3;
    // Timing and codes: tracking length in SAR clocks, top trial bit index, first trial word and sign flip
    localparam logic [1:0] TRACK_SAR_CLOCKS = 2'h3;
    localparam logic [2:0] TOP_BIT_INDEX = 3'h7;
    localparam logic [7:0] TRIAL_START = 8'h80;
    localparam logic [7:0] SIGN_FLIP = 8'h80;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_TRACK = 2'b01,
        ST_CONVERT = 2'b11
    } conv_state_type;

    typedef struct packed {
        logic powered;
        logic tracking;
        logic differential;
        logic [2:0] channel;
        logic [1:0] gain;
    } analog_ctrl_type;

    typedef struct packed {
        logic write;
        logic [7:0] addr;
        logic [7:0] wdata;
    } sfr_req_type;
endpackage : adc8_pkg

// ### adc8_control.sv
// Control, sequencing, registers and window detector of the 8-bit SAR converter
`timescale 1ns/10ps
module adc8_control (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire adc8_pkg::sfr_req_type sfr_req,
    output logic [7:0] sfr_rdata,
    input wire logic timer3_overflow,
    input wire logic timer2_overflow,
    input wire logic companion_start_bit,
    input wire logic external_start_pin,
    input wire logic comparator_high,
    output logic [7:0] sar_trial,
    output adc8_pkg::analog_ctrl_type analog_ctrl
);
    logic [3:0] pair_differential;
    logic [2:0] channel_code;
    logic [4:0] sar_clock_divider;
    logic [1:0] gain_code;
    logic converter_on;
    logic low_power_track;
    logic conversion_done_flag;
    logic [2:0] start_source;
    logic window_match_flag;
    logic [7:0] conversion_result;
    logic [7:0] greater_than_limit;
    logic [7:0] less_than_limit;
    adc8_pkg::conv_state_type state;
    logic [4:0] div_count;
    logic [1:0] track_count;
    logic [2:0] bit_index;
    logic [2:0] pin_sync;
    logic pin_level;
    logic conversion_running;

    logic sar_tick;
    logic selected_differential;
    logic wr_ctrl;
    logic software_start;
    logic pin_rise;
    logic trigger;
    logic last_tick;
    logic [7:0] final_code;
    logic [7:0] next_result;

    // Outside-window by default; inside when the limits are ordered low-to-high
    function automatic logic window_hit(input logic [7:0] code, input logic [7:0] gt_limit,
                                        input logic [7:0] lt_limit, input logic signed_mode);
        logic above;
        logic below;
        logic ordered;
        above = signed_mode ? ($signed(code) > $signed(gt_limit)) : (code > gt_limit);
        below = signed_mode ? ($signed(code) < $signed(lt_limit)) : (code < lt_limit);
        ordered = signed_mode ? ($signed(gt_limit) < $signed(lt_limit)) : (gt_limit < lt_limit);
        if (ordered) begin
            window_hit = above && below;
        end else begin
            window_hit = above || below;
        end
    endfunction : window_hit

    // Odd member of a pair follows the pair bit too: its code is undefined anyway
    assign selected_differential = pair_differential[channel_code[2:1]];
    assign sar_tick = (div_count == sar_clock_divider);
    assign wr_ctrl = sfr_req.write && (sfr_req.addr == adc8_pkg::ADDR_CTRL);
    assign software_start = wr_ctrl && sfr_req.wdata[adc8_pkg::CTRL_BUSY_BIT];
    assign pin_rise = pin_sync[1] && pin_sync[2] && !pin_level;
    assign last_tick = (state == adc8_pkg::ST_CONVERT) && sar_tick && (bit_index == 3'h0);
    assign final_code = comparator_high ? sar_trial : (sar_trial & ~(8'h01 << bit_index));
    assign next_result = selected_differential ? (final_code ^ adc8_pkg::SIGN_FLIP) : final_code;

    always_comb begin
        trigger = 1'b0;
        if (converter_on && (state == adc8_pkg::ST_IDLE)) begin
            if (start_source[2]) begin
                trigger = companion_start_bit;
            end else begin
                case (start_source)
                    adc8_pkg::SRC_SOFTWARE: trigger = software_start;
                    adc8_pkg::SRC_TIMER3: trigger = timer3_overflow;
                    adc8_pkg::SRC_PIN: trigger = pin_rise;
                    adc8_pkg::SRC_TIMER2: trigger = timer2_overflow;
                    default: trigger = 1'b0;
                endcase
            end
        end
    end

    // Start pin: level taken when stages two and three agree; reset to its idle high so no false edge
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            pin_sync <= 3'h7;
            pin_level <= 1'b1;
        end else begin
            pin_sync <= {pin_sync[1:0], external_start_pin};
            if (pin_sync[1] == pin_sync[2]) begin
                pin_level <= pin_sync[2];
            end
        end
    end

    // SAR clock divider; restarted by a trigger so tracking spans whole SAR clocks
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            div_count <= 5'h00;
        end else if (trigger || sar_tick || !converter_on) begin
            div_count <= 5'h00;
        end else begin
            div_count <= div_count + 5'h01;
        end
    end

    // Conversion sequence
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            state <= adc8_pkg::ST_IDLE;
            track_count <= 2'h0;
            bit_index <= 3'h0;
            sar_trial <= 8'h00;
        end else begin
            case (state)
                adc8_pkg::ST_IDLE: begin
                    if (trigger) begin
                        track_count <= 2'h0;
                        bit_index <= adc8_pkg::TOP_BIT_INDEX;
                        sar_trial <= adc8_pkg::TRIAL_START;
                        // Pin mode already tracked while the pin was low
                        if (low_power_track && (start_source != adc8_pkg::SRC_PIN)) begin
                            state <= adc8_pkg::ST_TRACK;
                        end else begin
                            state <= adc8_pkg::ST_CONVERT;
                        end
                    end
                end
                adc8_pkg::ST_TRACK: begin
                    if (!converter_on) begin
                        state <= adc8_pkg::ST_IDLE;
                    end else if (sar_tick) begin
                        track_count <= track_count + 2'h1;
                        if (track_count == adc8_pkg::TRACK_SAR_CLOCKS - 2'h1) begin
                            state <= adc8_pkg::ST_CONVERT;
                        end
                    end
                end
                adc8_pkg::ST_CONVERT: begin
                    if (!converter_on) begin
                        state <= adc8_pkg::ST_IDLE;
                    end else if (sar_tick) begin
                        if (bit_index == 3'h0) begin
                            sar_trial <= final_code;
                            state <= adc8_pkg::ST_IDLE;
                        end else begin
                            sar_trial <= final_code | (8'h01 << (bit_index - 3'h1));
                            bit_index <= bit_index - 3'h1;
                        end
                    end
                end
                default: state <= adc8_pkg::ST_IDLE;
            endcase
        end
    end

    // Busy mirrors a running conversion, tracking period included
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            conversion_running <= 1'b0;
        end else begin
            conversion_running <= (state != adc8_pkg::ST_IDLE);
        end
    end

    // Configuration registers; unused bits are never stored
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            pair_differential <= adc8_pkg::RST_PAIR[3:0];
            channel_code <= adc8_pkg::RST_CHAN[2:0];
            sar_clock_divider <= adc8_pkg::RST_CLKGAIN[7:3];
            gain_code <= adc8_pkg::RST_CLKGAIN[1:0];
            greater_than_limit <= adc8_pkg::RST_GT;
            less_than_limit <= adc8_pkg::RST_LT;
        end else if (sfr_req.write) begin
            case (sfr_req.addr)
                adc8_pkg::ADDR_PAIR: pair_differential <= sfr_req.wdata[3:0];
                adc8_pkg::ADDR_CHAN: channel_code <= sfr_req.wdata[2:0];
                adc8_pkg::ADDR_CLKGAIN: begin
                    sar_clock_divider <= sfr_req.wdata[adc8_pkg::CLK_DIV_LSB +: 5];
                    gain_code <= sfr_req.wdata[adc8_pkg::GAIN_LSB +: 2];
                end
                adc8_pkg::ADDR_GT: greater_than_limit <= sfr_req.wdata;
                adc8_pkg::ADDR_LT: less_than_limit <= sfr_req.wdata;
                default: ;
            endcase
        end
    end

    // Control register bits written by software only
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            converter_on <= adc8_pkg::RST_CTRL[adc8_pkg::CTRL_ON_BIT];
            low_power_track <= adc8_pkg::RST_CTRL[adc8_pkg::CTRL_TRACK_BIT];
            start_source <= adc8_pkg::RST_CTRL[adc8_pkg::CTRL_SRC_LSB +: 3];
        end else if (wr_ctrl) begin
            converter_on <= sfr_req.wdata[adc8_pkg::CTRL_ON_BIT];
            low_power_track <= sfr_req.wdata[adc8_pkg::CTRL_TRACK_BIT];
            start_source <= sfr_req.wdata[adc8_pkg::CTRL_SRC_LSB +: 3];
        end
    end

    // Sticky flags: a hardware set in the same cycle as a software write wins
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            conversion_done_flag <= adc8_pkg::RST_CTRL[adc8_pkg::CTRL_DONE_BIT];
            window_match_flag <= adc8_pkg::RST_CTRL[adc8_pkg::CTRL_WIN_BIT];
        end else begin
            if (conversion_running && (state == adc8_pkg::ST_IDLE)) begin
                conversion_done_flag <= 1'b1;
            end else if (wr_ctrl) begin
                conversion_done_flag <= sfr_req.wdata[adc8_pkg::CTRL_DONE_BIT];
            end
            if (last_tick && converter_on
                && window_hit(next_result, greater_than_limit, less_than_limit, selected_differential)) begin
                window_match_flag <= 1'b1;
            end else if (wr_ctrl) begin
                window_match_flag <= sfr_req.wdata[adc8_pkg::CTRL_WIN_BIT];
            end
        end
    end

    // Result word; a finishing conversion overrides a software write
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            conversion_result <= adc8_pkg::RST_RESULT;
        end else if (last_tick && converter_on) begin
            conversion_result <= next_result;
        end else if (sfr_req.write && (sfr_req.addr == adc8_pkg::ADDR_RESULT)) begin
            conversion_result <= sfr_req.wdata;
        end
    end

    // Read data is registered: valid one cycle after the address
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            sfr_rdata <= 8'h00;
        end else begin
            case (sfr_req.addr)
                adc8_pkg::ADDR_PAIR: sfr_rdata <= {4'h0, pair_differential};
                adc8_pkg::ADDR_CHAN: sfr_rdata <= {5'h00, channel_code};
                adc8_pkg::ADDR_CLKGAIN: sfr_rdata <= {sar_clock_divider, 1'b0, gain_code};
                adc8_pkg::ADDR_RESULT: sfr_rdata <= conversion_result;
                adc8_pkg::ADDR_GT: sfr_rdata <= greater_than_limit;
                adc8_pkg::ADDR_LT: sfr_rdata <= less_than_limit;
                adc8_pkg::ADDR_CTRL: sfr_rdata <= {converter_on, low_power_track, conversion_done_flag,
                                                   conversion_running, start_source, window_match_flag};
                default: sfr_rdata <= 8'h00;
            endcase
        end
    end

    // Analog front-end controls
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            analog_ctrl <= '0;
        end else begin
            analog_ctrl.powered <= converter_on;
            analog_ctrl.differential <= selected_differential;
            analog_ctrl.channel <= channel_code;
            analog_ctrl.gain <= gain_code;
            if (!converter_on) begin
                analog_ctrl.tracking <= 1'b0;
            end else if (state == adc8_pkg::ST_TRACK) begin
                analog_ctrl.tracking <= 1'b1;
            end else if (state != adc8_pkg::ST_IDLE) begin
                analog_ctrl.tracking <= 1'b0;
            end else if (!low_power_track) begin
                analog_ctrl.tracking <= 1'b1;
            end else begin
                analog_ctrl.tracking <= (start_source == adc8_pkg::SRC_PIN) && !pin_level;
            end
        end
    end
endmodule : adc8_control

// ### adc8_analog_model.sv
// Analog side model: track-and-hold input feeding an ideal comparator
`timescale 1ns/10ps
module adc8_analog_model (
    input wire logic [7:0] sar_trial,
    input wire logic tracking,
    input wire logic [7:0] level,
    output logic comparator_high
);
    logic [7:0] held = 8'h00;
    // Level is offset-binary for pairs, so the SAR ends on it exactly
    always @* if (tracking) held = level;
    assign comparator_high = (held >= sar_trial);
endmodule : adc8_analog_model

// ### adc8_control_chk.sv
// Port-level assertions for the SAR converter control block
`timescale 1ns/10ps
module adc8_control_chk (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire adc8_pkg::sfr_req_type sfr_req,
    input wire logic [7:0] sfr_rdata,
    input wire adc8_pkg::analog_ctrl_type analog_ctrl
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    pair_spare_zero_a: assert property ($past(sfr_req.addr) == adc8_pkg::ADDR_PAIR |-> sfr_rdata[7:4] == 4'h0)
        else $error("pair spare bits not zero");
    chan_spare_zero_a: assert property ($past(sfr_req.addr) == adc8_pkg::ADDR_CHAN |-> sfr_rdata[7:3] == 5'h00)
        else $error("channel spare bits not zero");
    clk_spare_zero_a: assert property ($past(sfr_req.addr) == adc8_pkg::ADDR_CLKGAIN |-> !sfr_rdata[2])
        else $error("clock spare bit not zero");
    off_no_track_a: assert property (!analog_ctrl.powered |-> !analog_ctrl.tracking)
        else $error("tracking while powered down");
    // Analog controls trail the configuration register by one more stage
    gain_follows_a: assert property (sfr_req.write && sfr_req.addr == adc8_pkg::ADDR_CLKGAIN
        |-> ##2 analog_ctrl.gain == $past(sfr_req.wdata[1:0], 2)) else $error("gain not applied");
    chan_follows_a: assert property (sfr_req.write && sfr_req.addr == adc8_pkg::ADDR_CHAN
        |-> ##2 analog_ctrl.channel == $past(sfr_req.wdata[2:0], 2)) else $error("channel not applied");
    pair_follows_a: assert property (sfr_req.write && sfr_req.addr == adc8_pkg::ADDR_PAIR
        |-> ##2 analog_ctrl.differential == $past(sfr_req.wdata[analog_ctrl.channel[2:1]], 2))
        else $error("pair not applied");
    done_on_fall_a: assert property ($past(sfr_req.addr) == adc8_pkg::ADDR_CTRL
        && $past(sfr_req.addr, 2) == adc8_pkg::ADDR_CTRL && $past(sfr_rdata[4]) && !sfr_rdata[4] |-> sfr_rdata[5])
        else $error("done not set on busy fall");
    done_sticky_a: assert property ($past(sfr_req.addr) == adc8_pkg::ADDR_CTRL
        && $past(sfr_req.addr, 2) == adc8_pkg::ADDR_CTRL && $past(sfr_rdata[5]) && !sfr_rdata[5]
        |-> $past(sfr_req.write, 2)) else $error("done cleared by hardware");
    win_sticky_a: assert property ($past(sfr_req.addr) == adc8_pkg::ADDR_CTRL
        && $past(sfr_req.addr, 2) == adc8_pkg::ADDR_CTRL && $past(sfr_rdata[0]) && !sfr_rdata[0]
        |-> $past(sfr_req.write, 2)) else $error("window flag cleared by hardware");
endmodule : adc8_control_chk
bind adc8_control adc8_control_chk adc8_control_chk_inst (.clk_sys(clk_sys), .reset_n(reset_n),
    .sfr_req(sfr_req), .sfr_rdata(sfr_rdata), .analog_ctrl(analog_ctrl));

// ### test_adc8_control.sv
// Self-checking bench for the SAR converter control block
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin error_cnt++; $display("Error %s expected %h seen %h", nm, e, g); end end
module test_adc8_control;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    adc8_pkg::sfr_req_type sfr_req = '0;
    logic [7:0] sfr_rdata;
    logic [2:0] pulse = 3'h0;
    logic external_start_pin = 1'b1;
    logic comparator_high;
    logic [7:0] sar_trial;
    adc8_pkg::analog_ctrl_type analog_ctrl;
    logic [7:0] level = 8'h00;
    logic [31:0] rnd = 32'hBB31;
    int trk_cycles = 0;
    int error_cnt = 0;
    int n_checks = 0;
    logic [7:0] addrs [8] = '{adc8_pkg::ADDR_PAIR, adc8_pkg::ADDR_CHAN, adc8_pkg::ADDR_CLKGAIN, adc8_pkg::ADDR_RESULT,
        adc8_pkg::ADDR_CTRL, adc8_pkg::ADDR_GT, adc8_pkg::ADDR_LT, 8'h01};
    logic [7:0] rsts [8] = '{8'h00, 8'h00, 8'hF8, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h00};
    logic [7:0] spare [3] = '{8'h0F, 8'h07, 8'hFB};
    adc8_control adc8_control_inst (.clk_sys(clk_sys), .reset_n(reset_n), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
        .timer3_overflow(pulse[0]), .timer2_overflow(pulse[1]), .companion_start_bit(pulse[2]),
        .external_start_pin(external_start_pin), .comparator_high(comparator_high), .sar_trial(sar_trial),
        .analog_ctrl(analog_ctrl));
    adc8_analog_model adc8_analog_model_inst (.sar_trial(sar_trial), .tracking(analog_ctrl.tracking),
        .level(level), .comparator_high(comparator_high));
    initial forever #10 clk_sys = ~clk_sys;
    always @(posedge clk_sys) trk_cycles <= trk_cycles + int'(analog_ctrl.tracking);
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    // Flipping the sign bit turns signed order into unsigned order
    function automatic logic win_exp(input logic [7:0] r, input logic [7:0] gt, input logic [7:0] lt, input logic sg);
        logic [7:0] m;
        m = {sg, 7'h00};
        if ((gt ^ m) < (lt ^ m)) return ((r ^ m) > (gt ^ m)) && ((r ^ m) < (lt ^ m));
        return ((r ^ m) < (lt ^ m)) || ((r ^ m) > (gt ^ m));
    endfunction : win_exp
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        sfr_req <= '{1'b1, a, d};
        @(posedge clk_sys);
        sfr_req.write <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        sfr_req.addr <= a;
        @(posedge clk_sys);
        #1 d = sfr_rdata;
    endtask : rd
    task automatic fire(input logic [2:0] src, input logic [7:0] ctl);
        if (src == adc8_pkg::SRC_SOFTWARE) begin
            wr(adc8_pkg::ADDR_CTRL, ctl | 8'h10);
        end else if (src == adc8_pkg::SRC_PIN) begin
            @(posedge clk_sys);
            external_start_pin <= 1'b0;
            repeat (12) @(posedge clk_sys);
            #1 `CHK("pin low tracking", 1'b1, analog_ctrl.tracking)
            @(posedge clk_sys);
            external_start_pin <= 1'b1;
        end else begin
            @(posedge clk_sys);
            pulse <= src[2] ? 3'h4 : (src[1] ? 3'h2 : 3'h1);
            @(posedge clk_sys);
            pulse <= 3'h0;
        end
    endtask : fire
    task automatic convert(input logic trk, input logic [2:0] src, input logic [7:0] pair, input logic [2:0] ch,
        input logic [7:0] gt, input logic [7:0] lt, input logic [7:0] lv);
        logic [7:0] ctl;
        logic [7:0] d;
        logic [7:0] res;
        logic dif;
        logic seen_busy;
        rnd = lfsr(rnd);
        dif = pair[ch[2:1]];
        res = dif ? lv ^ 8'h80 : lv;
        level <= lv;
        ctl = {1'b1, trk, 2'b00, src, 1'b0};
        wr(adc8_pkg::ADDR_PAIR, pair);
        wr(adc8_pkg::ADDR_CHAN, {5'h00, ch});
        wr(adc8_pkg::ADDR_CLKGAIN, {5'h08, 1'b0, rnd[1:0]});
        wr(adc8_pkg::ADDR_GT, gt);
        wr(adc8_pkg::ADDR_LT, lt);
        wr(adc8_pkg::ADDR_CTRL, ctl);
        repeat (3) @(posedge clk_sys);
        #1 `CHK("analog control", {1'b1, !trk, dif, ch, rnd[1:0]}, analog_ctrl)
        trk_cycles = 0;
        fire(src, ctl);
        d = 8'h00;
        seen_busy = 1'b0;
        for (int i = 0; i < 300 && d[5] !== 1'b1; i++) begin
            rd(adc8_pkg::ADDR_CTRL, d);
            seen_busy = seen_busy | d[4];
        end
        `CHK("busy seen", 1'b1, seen_busy)
        `CHK("done and busy", 2'b10, d[5:4])
        `CHK("window flag", win_exp(res, gt, lt, dif), d[0])
        if (trk && src != adc8_pkg::SRC_PIN) `CHK("track cycles", 27, trk_cycles)
        rd(adc8_pkg::ADDR_RESULT, d);
        `CHK("result", res, d)
        $display("conversion test done mode %0d source %0d", trk, src);
    endtask : convert
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : complete_run
    initial begin
        repeat (40000) @(posedge clk_sys);
        error_cnt++;
        $display("Error watchdog expected finish seen timeout");
        complete_run();
    end
    initial begin
        logic [7:0] d;
        repeat (2) @(posedge clk_sys);
        reset_n <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            rd(addrs[i], d);
            `CHK("reset value", rsts[i], d)
        end
        for (int i = 0; i < 3; i++) begin
            wr(addrs[i], 8'hFF);
            rd(addrs[i], d);
            `CHK("spare bits", spare[i], d)
        end
        wr(adc8_pkg::ADDR_CTRL, 8'h10);
        wr(adc8_pkg::ADDR_CTRL, 8'h82);
        wr(adc8_pkg::ADDR_CTRL, 8'h92);
        repeat (20) @(posedge clk_sys);
        rd(adc8_pkg::ADDR_CTRL, d);
        `CHK("refused start", 2'b00, d[5:4])
        $display("register test done");
        for (int t = 0; t < 2; t++) begin
            for (int s = 0; s < 8; s++) begin
                rnd = lfsr(rnd);
                convert(t[0], s[2:0], {4'h0, rnd[3:0]}, rnd[6:4], rnd[15:8], rnd[23:16], rnd[31:24]);
            end
        end
        convert(1'b0, 3'h0, 8'h00, 3'h0, 8'h10, 8'h20, 8'h10);
        convert(1'b0, 3'h0, 8'h00, 3'h1, 8'h10, 8'h20, 8'h15);
        convert(1'b1, 3'h1, 8'h00, 3'h2, 8'h20, 8'h10, 8'h20);
        convert(1'b0, 3'h3, 8'h01, 3'h1, 8'hF0, 8'h10, 8'h78);
        convert(1'b1, 3'h4, 8'h0F, 3'h7, 8'h80, 8'h7F, 8'h00);
        wr(adc8_pkg::ADDR_CTRL, 8'h00);
        repeat (4) @(posedge clk_sys);
        complete_run();
    end
endmodule : test_adc8_control
